// ===== acrb_pkg.sv
// Constants and types shared by the amplifier control register bank.
// Assumes an 8-bit register space reached over a two-wire serial port.
package acrb_pkg;

    // ************************************************************
    // Register offsets and special values
    // ************************************************************
    localparam logic [7:0] ADDR_IDENTITY   = 8'h00;
    localparam logic [7:0] ADDR_SYSTEM     = 8'h01;
    localparam logic [7:0] ADDR_MODE       = 8'h02;
    localparam logic [7:0] ADDR_LIMIT      = 8'h03;
    localparam logic [7:0] ADDR_PUMP_PARAM = 8'h04;
    localparam logic [7:0] ADDR_GAIN       = 8'h05;
    localparam logic [7:0] SOFT_RESET_CODE = 8'haa;
    localparam logic [7:0] READ_UNMAPPED   = 8'h00;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_SYSTEM     = 8'h06;
    localparam logic [7:0] RST_MODE       = 8'h0c;
    localparam logic [7:0] RST_LIMIT      = 8'h08;
    localparam logic [7:0] RST_PUMP_PARAM = 8'h05;
    localparam logic [7:0] RST_GAIN       = 8'h0c;

    // ************************************************************
    // Field positions and code ranges
    // ************************************************************
    localparam int SYS_AMP_BIT  = 2;
    localparam int SYS_PUMP_BIT = 1;
    localparam int SYS_PU_BIT   = 0;
    localparam int MODE_ADP_BIT = 4;
    localparam int MODE_DBL_BIT = 3;
    localparam int MODE_SPK_BIT = 2;
    localparam int MODE_AB_BIT  = 0;
    localparam int LIMIT_W      = 4;
    localparam int GAIN_W       = 5;

    localparam logic [3:0] LIMIT_FIRST_RSVD = 4'hb;
    localparam logic [4:0] GAIN_RCVD_MIN    = 5'h13;
    localparam logic [4:0] GAIN_RCVD_MAX    = 5'h1a;
    localparam logic [4:0] GAIN_RCVAB_MIN   = 5'h19;

    // ************************************************************
    // Serial port
    // ************************************************************
    localparam logic [4:0] DEV_ADDR_BASE  = 5'h16;
    localparam logic [3:0] BIT_COUNT_LAST = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE, ST_DEVADDR, ST_DEVACK, ST_REGADDR, ST_REGACK,
        ST_WRDATA, ST_WRACK, ST_RDLOAD, ST_RDDATA, ST_RDACK
    } acrb_state_t;

endpackage : acrb_pkg

// ===== acrb_reg_file.sv
// Register storage with write legalisation and read multiplexer.
// Assumes single-cycle write strobes from the serial front end.
`timescale 1ns/100ps
module acrb_reg_file
    import acrb_pkg::*;
#(
    parameter logic [7:0] IDENTITY_VALUE = 8'h3c  // Arbitrary value
) (
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic              wrEn,
    input  wire logic [7:0]        wrAddr,
    input  wire logic [7:0]        wrData,
    input  wire logic [7:0]        rdAddr,
    output logic      [7:0]        rdData,
    output logic                   amplifierOn,
    output logic                   pumpOn,
    output logic                   softPowerUp,
    output logic                   adaptiveFunctionOn,
    output logic                   pumpDoublerSelect,
    output logic                   speakerModeSelect,
    output logic                   linearClassSelect,
    output logic [LIMIT_W-1:0]     pumpVoltageLimit,
    output logic [GAIN_W-1:0]      gainCode
);

    // ************************************************************
    // Write decode and legalisation
    // ************************************************************
    wire              softReset = wrEn && wrAddr == ADDR_IDENTITY
                                  && wrData == SOFT_RESET_CODE;
    wire              wrSystem  = wrEn && wrAddr == ADDR_SYSTEM;
    wire              wrMode    = wrEn && wrAddr == ADDR_MODE;
    wire              wrLimit   = wrEn && wrAddr == ADDR_LIMIT;
    wire              wrGain    = wrEn && wrAddr == ADDR_GAIN;
    wire [GAIN_W-1:0] gainIn    = wrData[GAIN_W-1:0];
    wire              limitOk   = wrData[LIMIT_W-1:0] < LIMIT_FIRST_RSVD;
    wire              rcvDOk    = gainIn >= GAIN_RCVD_MIN
                                  && gainIn <= GAIN_RCVD_MAX;
    wire              rcvAbOk   = gainIn >= GAIN_RCVAB_MIN;
    // Legality follows the mode held before this write
    wire              gainOk    = speakerModeSelect
                                  || (linearClassSelect ? rcvAbOk : rcvDOk);

    always_ff @(posedge core_clk) begin
        if (srst || softReset) begin
            amplifierOn        <= RST_SYSTEM[SYS_AMP_BIT];
            pumpOn             <= RST_SYSTEM[SYS_PUMP_BIT];
            softPowerUp        <= RST_SYSTEM[SYS_PU_BIT];
            adaptiveFunctionOn <= RST_MODE[MODE_ADP_BIT];
            pumpDoublerSelect  <= RST_MODE[MODE_DBL_BIT];
            speakerModeSelect  <= RST_MODE[MODE_SPK_BIT];
            linearClassSelect  <= RST_MODE[MODE_AB_BIT];
            pumpVoltageLimit   <= RST_LIMIT[LIMIT_W-1:0];
            gainCode           <= RST_GAIN[GAIN_W-1:0];
        end else begin
            if (wrSystem) begin
                amplifierOn <= wrData[SYS_AMP_BIT];
                pumpOn      <= wrData[SYS_PUMP_BIT];
                softPowerUp <= wrData[SYS_PU_BIT];
            end
            if (wrMode) begin
                adaptiveFunctionOn <= wrData[MODE_ADP_BIT];
                pumpDoublerSelect  <= wrData[MODE_DBL_BIT];
                speakerModeSelect  <= wrData[MODE_SPK_BIT];
                linearClassSelect  <= wrData[MODE_AB_BIT];
            end
            if (wrLimit) begin
                pumpVoltageLimit <= limitOk ? wrData[LIMIT_W-1:0]
                                            : RST_LIMIT[LIMIT_W-1:0];
            end
            if (wrGain) begin
                gainCode <= gainOk ? gainIn : RST_GAIN[GAIN_W-1:0];
            end
        end
    end

    // ************************************************************
    // Read multiplexer, reserved bits fixed at reset value
    // ************************************************************
    wire [7:0] sysByte  = {5'h00, amplifierOn, pumpOn, softPowerUp};
    wire [7:0] modeByte = {3'h0, adaptiveFunctionOn, pumpDoublerSelect,
                           speakerModeSelect, 1'b0, linearClassSelect};
    wire [7:0] limByte  = {4'h0, pumpVoltageLimit};
    wire [7:0] gainByte = {3'h0, gainCode};

    assign rdData = (rdAddr == ADDR_IDENTITY)   ? IDENTITY_VALUE :
                    (rdAddr == ADDR_SYSTEM)     ? sysByte :
                    (rdAddr == ADDR_MODE)       ? modeByte :
                    (rdAddr == ADDR_LIMIT)      ? limByte :
                    (rdAddr == ADDR_PUMP_PARAM) ? RST_PUMP_PARAM :
                    (rdAddr == ADDR_GAIN)       ? gainByte : READ_UNMAPPED;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_id_fixed;
        rdAddr == ADDR_IDENTITY |-> rdData == IDENTITY_VALUE;
    endproperty
    a_id_fixed: assert property (p_id_fixed)
        else $error("identity read wrong");

    property p_soft_reset;
        softReset |=> gainCode == RST_GAIN[GAIN_W-1:0] && amplifierOn
            && pumpOn && !softPowerUp && speakerModeSelect;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset left state");

    property p_power_write;
        wrSystem |=> softPowerUp == $past(wrData[SYS_PU_BIT])
            && amplifierOn == $past(wrData[SYS_AMP_BIT]);
    endproperty
    a_power_write: assert property (p_power_write)
        else $error("power bits not written");

    property p_limit_rsvd;
        wrLimit && wrData[LIMIT_W-1:0] >= LIMIT_FIRST_RSVD
            |=> pumpVoltageLimit == RST_LIMIT[LIMIT_W-1:0];
    endproperty
    a_limit_rsvd: assert property (p_limit_rsvd)
        else $error("reserved limit code kept");

    property p_gain_rcvd;
        wrGain && !speakerModeSelect && !linearClassSelect && !rcvDOk
            |=> gainCode == RST_GAIN[GAIN_W-1:0];
    endproperty
    a_gain_rcvd: assert property (p_gain_rcvd)
        else $error("reserved class D gain kept");

    property p_gain_rcvab;
        wrGain && !speakerModeSelect && linearClassSelect && rcvAbOk
            |=> gainCode == $past(gainIn);
    endproperty
    a_gain_rcvab: assert property (p_gain_rcvab)
        else $error("legal class AB gain lost");

    property p_pump_param;
        rdAddr == ADDR_PUMP_PARAM |-> rdData == RST_PUMP_PARAM;
    endproperty
    a_pump_param: assert property (p_pump_param)
        else $error("pump parameter changed");

    property p_rsvd_zero;
        rdAddr == ADDR_MODE |-> rdData[7:5] == 3'h0 && !rdData[1];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bit set");

endmodule : acrb_reg_file

// ===== acrb_serial_top.sv
// Two-wire serial slave in front of the amplifier control registers.
// Assumes SCL and SDA already synchronous and far slower than core_clk.
`timescale 1ns/100ps
module acrb_serial_top
    import acrb_pkg::*;
#(
    parameter logic [7:0] IDENTITY_VALUE = 8'h3c  // Arbitrary value
) (
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic              sclIn,
    input  wire logic              sdaIn,
    output logic                   sdaOut,
    output logic                   sdaOe,
    input  wire logic [1:0]        addrSelect,
    output logic                   amplifierOn,
    output logic                   pumpOn,
    output logic                   softPowerUp,
    output logic                   adaptiveFunctionOn,
    output logic                   pumpDoublerSelect,
    output logic                   speakerModeSelect,
    output logic                   linearClassSelect,
    output logic [LIMIT_W-1:0]     pumpVoltageLimit,
    output logic [GAIN_W-1:0]      gainCode
);

    // ************************************************************
    // Line edges and bus conditions
    // ************************************************************
    logic        sclPrev;
    logic        sdaPrev;
    acrb_state_t state;
    acrb_state_t next_state;
    logic [3:0]  bitCount;
    logic [3:0]  next_bitCount;
    logic [7:0]  shiftReg;
    logic [7:0]  next_shiftReg;
    logic [7:0]  pointer;
    logic [7:0]  next_pointer;
    logic        readMode;
    logic        next_readMode;
    logic        masterAck;
    logic        next_masterAck;
    logic        next_sdaOe;
    logic [7:0]  rdData;

    wire sclRise   = sclIn && !sclPrev;
    wire sclFall   = !sclIn && sclPrev;
    wire startSeen = sclIn && sclPrev && sdaPrev && !sdaIn;
    wire stopSeen  = sclIn && sclPrev && !sdaPrev && sdaIn;
    wire byteDone  = bitCount == BIT_COUNT_LAST;
    wire addrMatch = shiftReg[7:1] == {DEV_ADDR_BASE, addrSelect};
    wire wrEn      = state == ST_WRDATA && sclFall && byteDone && !startSeen
                     && !stopSeen;

    // Open-drain: only ever pulls low
    assign sdaOut = 1'b0;

    // ************************************************************
    // Register storage
    // ************************************************************
    acrb_reg_file #(
        .IDENTITY_VALUE     (IDENTITY_VALUE)
    ) u_regs (
        .core_clk           (core_clk),
        .srst               (srst),
        .wrEn               (wrEn),
        .wrAddr             (pointer),
        .wrData             (shiftReg),
        .rdAddr             (pointer),
        .rdData             (rdData),
        .amplifierOn        (amplifierOn),
        .pumpOn             (pumpOn),
        .softPowerUp        (softPowerUp),
        .adaptiveFunctionOn (adaptiveFunctionOn),
        .pumpDoublerSelect  (pumpDoublerSelect),
        .speakerModeSelect  (speakerModeSelect),
        .linearClassSelect  (linearClassSelect),
        .pumpVoltageLimit   (pumpVoltageLimit),
        .gainCode           (gainCode)
    );

    // ************************************************************
    // Byte engine
    // ************************************************************
    always_comb begin
        next_state     = state;
        next_bitCount  = bitCount;
        next_shiftReg  = shiftReg;
        next_pointer   = pointer;
        next_readMode  = readMode;
        next_masterAck = masterAck;
        if (startSeen) begin
            // Repeated start keeps the pointer for the read phase
            next_state    = ST_DEVADDR;
            next_bitCount = 4'h0;
        end else if (stopSeen) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
                ST_DEVADDR, ST_REGADDR, ST_WRDATA: begin
                    if (sclRise && !byteDone) begin
                        next_shiftReg = {shiftReg[6:0], sdaIn};
                        next_bitCount = bitCount + 4'h1;
                    end else if (sclFall && byteDone) begin
                        next_bitCount = 4'h0;
                        if (state == ST_WRDATA) begin
                            next_state = ST_WRACK;
                        end else if (state == ST_REGADDR) begin
                            next_pointer = shiftReg;
                            next_state   = ST_REGACK;
                        end else if (addrMatch) begin
                            next_readMode = shiftReg[0];
                            next_state    = ST_DEVACK;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_DEVACK: begin
                    if (sclFall) begin
                        next_state = readMode ? ST_RDLOAD : ST_REGADDR;
                    end
                end
                ST_REGACK: begin
                    if (sclFall) begin
                        next_state = ST_WRDATA;
                    end
                end
                ST_WRACK: begin
                    if (sclFall) begin
                        next_pointer = pointer + 8'h01;
                        next_state   = ST_WRDATA;
                    end
                end
                ST_RDLOAD: begin
                    next_shiftReg = rdData;
                    next_bitCount = 4'h0;
                    next_state    = ST_RDDATA;
                end
                ST_RDDATA: begin
                    if (sclRise) begin
                        next_bitCount = bitCount + 4'h1;
                    end else if (sclFall && byteDone) begin
                        next_bitCount = 4'h0;
                        next_state    = ST_RDACK;
                    end else if (sclFall) begin
                        next_shiftReg = {shiftReg[6:0], 1'b0};
                    end
                end
                ST_RDACK: begin
                    if (sclRise) begin
                        next_masterAck = !sdaIn;
                    end else if (sclFall && masterAck) begin
                        next_pointer = pointer + 8'h01;
                        next_state   = ST_RDLOAD;
                    end else if (sclFall) begin
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // Pull low for acknowledge and for zero read bits
    always_comb begin
        case (next_state)
            ST_DEVACK, ST_REGACK, ST_WRACK: next_sdaOe = 1'b1;
            ST_RDDATA:                      next_sdaOe = !next_shiftReg[7];
            default:                        next_sdaOe = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state     <= ST_IDLE;
            sclPrev   <= 1'b1;
            sdaPrev   <= 1'b1;
            bitCount  <= 4'h0;
            shiftReg  <= 8'h00;
            pointer   <= 8'h00;
            readMode  <= 1'b0;
            masterAck <= 1'b0;
            sdaOe     <= 1'b0;
        end else begin
            state     <= next_state;
            sclPrev   <= sclIn;
            sdaPrev   <= sdaIn;
            bitCount  <= next_bitCount;
            shiftReg  <= next_shiftReg;
            pointer   <= next_pointer;
            readMode  <= next_readMode;
            masterAck <= next_masterAck;
            sdaOe     <= next_sdaOe;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_wrAckEnd;
        state == ST_WRACK && sclFall && !startSeen && !stopSeen;
    endsequence

    sequence s_rdAckEnd;
        state == ST_RDACK && sclFall && masterAck && !startSeen
            && !stopSeen;
    endsequence

    property p_wr_step;
        s_wrAckEnd |=> pointer == $past(pointer) + 8'h01
            && state == ST_WRDATA;
    endproperty
    a_wr_step: assert property (p_wr_step)
        else $error("write pointer did not advance");

    property p_rd_step;
        s_rdAckEnd |=> pointer == $past(pointer) + 8'h01
            ##1 state == ST_RDDATA && shiftReg == rdData;
    endproperty
    a_rd_step: assert property (p_rd_step)
        else $error("read pointer or data wrong");

    property p_bad_addr;
        state == ST_DEVADDR && sclFall && byteDone && !addrMatch
            && !startSeen && !stopSeen |=> state == ST_IDLE && !sdaOe;
    endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("foreign address acknowledged");

endmodule : acrb_serial_top

// ===== acrb_host_model.sv
// Behavioural two-wire bus master for the register bank bench.
// Assumes SDA is resolved outside with a pull-up and fed back as sdaIn.
`timescale 1ns/100ps
module acrb_host_model (
    input  wire logic core_clk,
    input  wire logic sdaIn,
    output logic      scl,
    output logic      sdaLow
);
    initial begin
        scl    = 1'b1;
        sdaLow = 1'b0;
    end

    // ************************************************************
    // Bus phases
    // ************************************************************
    // Four clocks a phase, above the slave's three-clock minimum
    task automatic hold_phase();
        repeat (4) @(posedge core_clk);
    endtask : hold_phase

    // Also serves as repeated start, entered with SCL low
    task automatic start_cond();
        sdaLow <= 1'b0;
        hold_phase();
        scl <= 1'b1;
        hold_phase();
        sdaLow <= 1'b1;
        hold_phase();
        scl <= 1'b0;
        hold_phase();
    endtask : start_cond

    task automatic stop_cond();
        sdaLow <= 1'b1;
        hold_phase();
        scl <= 1'b1;
        hold_phase();
        sdaLow <= 1'b0;
        hold_phase();
    endtask : stop_cond

    task automatic put_bit(input logic b, output logic r);
        sdaLow <= ~b;
        hold_phase();
        scl <= 1'b1;
        hold_phase();
        r = sdaIn;
        scl <= 1'b0;
        hold_phase();
    endtask : put_bit

    // ************************************************************
    // Bytes, MSB first
    // ************************************************************
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
        end
        put_bit(1'b1, r);
        ack = ~r;
    endtask : send_byte

    task automatic recv_byte(input logic ackIt, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            put_bit(1'b1, r);
            d = {d[6:0], r};
        end
        put_bit(~ackIt, r);
    endtask : recv_byte
endmodule : acrb_host_model

// ===== tb_top.sv
// Self-checking bench for the amplifier control register bank.
// Assumes the serial top with address straps fixed at 2'b01.
`timescale 1ns/100ps
module tb_top
    import acrb_pkg::*;
;
    localparam logic [7:0] ID_VAL = 8'h4b;  // Arbitrary value
    localparam logic [7:0] DEV_W  = {DEV_ADDR_BASE, 2'b01, 1'b0};
    logic            core_clk;
    logic            srst;
    logic            scl;
    logic            sdaLow;
    logic            sdaOut;
    logic            sdaOe;
    logic            ampOn;
    logic            pumpOn;
    logic            puOn;
    logic            adpOn;
    logic            dblSel;
    logic            spkSel;
    logic            abSel;
    logic [3:0]      limit;
    logic [4:0]      gain;
    logic [7:0]      wrBuf[6];
    logic [7:0]      expBuf[7];
    int              errors;
    int              num_checks;
    // Pull-up wire; the slave only ever pulls low
    wire             sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));

    acrb_serial_top #(.IDENTITY_VALUE(ID_VAL)) acrb_serial_top_i (
        .core_clk(core_clk), .srst(srst), .sclIn(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelect(2'b01),
        .amplifierOn(ampOn), .pumpOn(pumpOn), .softPowerUp(puOn),
        .adaptiveFunctionOn(adpOn), .pumpDoublerSelect(dblSel),
        .speakerModeSelect(spkSel), .linearClassSelect(abSel),
        .pumpVoltageLimit(limit), .gainCode(gain));
    acrb_host_model acrb_host_model_i (
        .core_clk(core_clk), .sdaIn(sdaWire), .scl(scl), .sdaLow(sdaLow));

    // ************************************************************
    // Checking and bus helpers
    // ************************************************************
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_ack(input logic got, input logic exp);
        cmp_val({7'h0, got}, {7'h0, exp});
    endtask : cmp_ack

    task automatic addr_phase(input logic [7:0] a);
        logic ack;
        acrb_host_model_i.start_cond();
        acrb_host_model_i.send_byte(DEV_W, ack);
        cmp_ack(ack, 1'b1);
        acrb_host_model_i.send_byte(a, ack);
        cmp_ack(ack, 1'b1);
    endtask : addr_phase

    task automatic wr_burst(input logic [7:0] a, input int n);
        logic ack;
        addr_phase(a);
        for (int i = 0; i < n; i++) begin
            acrb_host_model_i.send_byte(wrBuf[i], ack);
            cmp_ack(ack, 1'b1);
        end
        acrb_host_model_i.stop_cond();
    endtask : wr_burst

    // Reads n bytes from a and compares each with expBuf
    task automatic rd_burst(input logic [7:0] a, input int n);
        logic       ack;
        logic [7:0] d;
        addr_phase(a);
        acrb_host_model_i.start_cond();
        acrb_host_model_i.send_byte(DEV_W | 8'h01, ack);
        cmp_ack(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            acrb_host_model_i.recv_byte(i < n - 1, d);
            cmp_val(d, expBuf[i]);
        end
        acrb_host_model_i.stop_cond();
    endtask : rd_burst

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        cmp_val({5'h0, ampOn, pumpOn, puOn}, RST_SYSTEM);
        cmp_val({3'h0, adpOn, dblSel, spkSel, 1'b0, abSel},
                RST_MODE);
        cmp_val({4'h0, limit}, RST_LIMIT);
        cmp_val({3'h0, gain}, RST_GAIN);
        expBuf = '{ID_VAL, 8'h06, 8'h0c, 8'h08, 8'h05, 8'h0c, 8'h00};
        rd_burst(8'h00, 7);
    endtask : t_reset

    // Reserved limit code and reserved bits all in one burst
    task automatic t_burst();
        wrBuf = '{8'hff, 8'hff, 8'h0b, 8'hff, 8'hff, 8'h00};
        wr_burst(8'h01, 5);
        cmp_val({5'h0, ampOn, pumpOn, puOn}, 8'h07);
        cmp_val({3'h0, adpOn, dblSel, spkSel, 1'b0, abSel}, 8'h1d);
        cmp_val({4'h0, limit}, 8'h08);
        expBuf = '{ID_VAL, 8'h07, 8'h1d, 8'h08, 8'h05, 8'h1f, 8'h00};
        rd_burst(8'h00, 6);
    endtask : t_burst

    task automatic t_power();
        wrBuf[0] = 8'h06;
        wr_burst(8'h01, 1);
        cmp_val({5'h0, ampOn, pumpOn, puOn}, 8'h06);
        // Amplifier and pump both off, power-up turned on
        wrBuf[0] = 8'h01;
        wr_burst(8'h01, 1);
        cmp_val({5'h0, ampOn, pumpOn, puOn}, 8'h01);
    endtask : t_power

    // Mode written ahead of gain in the same burst steers its legality
    task automatic t_gain();
        logic [7:0] tMode[5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
        logic [7:0] tGain[5] = '{8'h18, 8'h19, 8'h12, 8'h1a, 8'h1b};
        logic [7:0] tExp[5]  = '{8'h0c, 8'h19, 8'h0c, 8'h1a, 8'h0c};
        for (int i = 0; i < 5; i++) begin
            wrBuf = '{tMode[i], 8'h0a, 8'h00, tGain[i], 8'h00, 8'h00};
            wr_burst(8'h02, 4);
            cmp_val({3'h0, gain}, tExp[i]);
            cmp_val({7'h0, spkSel}, 8'h00);
            cmp_val({4'h0, dblSel, spkSel, 1'b0, abSel}, tMode[i]);
            cmp_val({4'h0, limit}, 8'h0a);
        end
    endtask : t_gain

    task automatic t_soft();
        logic ack;
        wrBuf[0] = 8'h55;
        wr_burst(8'h00, 1);
        // A plain write to the identity offset must neither land nor reset
        cmp_val({4'h0, limit}, 8'h0a);
        expBuf[0] = ID_VAL;
        rd_burst(8'h00, 1);
        wrBuf[0] = SOFT_RESET_CODE;
        wr_burst(8'h00, 1);
        t_reset();
        acrb_host_model_i.start_cond();
        acrb_host_model_i.send_byte(DEV_W ^ 8'h02, ack);
        cmp_ack(ack, 1'b0);
        acrb_host_model_i.stop_cond();
    endtask : t_soft

    // ************************************************************
    // Clock, reset, sequence
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        repeat (40000) @(posedge core_clk);
        errors++;
        final_report();
    end

    initial begin
        errors     = 0;
        num_checks = 0;
        srst       = 1'b1;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_burst();
        t_power();
        t_gain();
        t_soft();
        final_report();
    end
endmodule : tb_top
